// [hdl/pwaq_params.svh]
// pwaq_params.svh: offsets, field positions, reset values of the action-qualifier block
`ifndef PWAQ_PARAMS_SVH
`define PWAQ_PARAMS_SVH

// ==========================================================
// register byte offsets
`define PWAQ_OFS_CTL_FIRST   12'h000
`define PWAQ_OFS_CTL_SECOND  12'h004
`define PWAQ_OFS_STATUS      12'h008
`define PWAQ_ADDR_W          12

// ==========================================================
// action control field positions (lsb of each two-bit field)
`define PWAQ_CTL_COMPARE_VALUE_SECOND_DN_LSB 10
`define PWAQ_CTL_COMPARE_VALUE_SECOND_UP_LSB 8
`define PWAQ_CTL_COMPARE_VALUE_FIRST_DN_LSB 6
`define PWAQ_CTL_COMPARE_VALUE_FIRST_UP_LSB 4
`define PWAQ_CTL_PERIOD_LSB  2
`define PWAQ_CTL_ZERO_LSB    0
`define PWAQ_CTL_USED_MSB    11
`define PWAQ_CTL_W           12

// ==========================================================
// status field positions
`define PWAQ_STS_OUT_FIRST   0
`define PWAQ_STS_OUT_SECOND  1
`define PWAQ_STS_DIR         2
`define PWAQ_STS_UPDOWN      3

// ==========================================================
// reset values
`define PWAQ_RST_CTL_FIRST   12'h000
`define PWAQ_RST_CTL_SECOND  12'h000

// ==========================================================
// bus responses
`define PWAQ_RESP_OKAY       2'h0
`define PWAQ_RESP_SLVERR     2'h2

`endif

// [hdl/pwaq_pkg.sv]
// pwaq_pkg.sv: types shared by the action-qualifier files
package pwaq_pkg;

    // ==========================================================
    // action encoding of every two-bit field
    typedef enum logic [1:0] {
        PWAQ_ACT_NONE   = 2'h0,
        PWAQ_ACT_CLEAR  = 2'h1,
        PWAQ_ACT_SET    = 2'h2,
        PWAQ_ACT_TOGGLE = 2'h3
    } pwaq_act_t;

    // ==========================================================
    // one output's control fields, msb first as in the register
    typedef struct packed {
        pwaq_act_t compare_value_second_down_action;
        pwaq_act_t compare_value_second_up_action;
        pwaq_act_t compare_value_first_down_action;
        pwaq_act_t compare_value_first_up_action;
        pwaq_act_t period_match_action;
        pwaq_act_t zero_match_action;
    } pwaq_ctl_t;

    // ==========================================================
    // sampled time-base events, direction 1 = up
    typedef struct packed {
        logic eq_zero;
        logic eq_period;
        logic eq_compare_value_first;
        logic eq_compare_value_second;
        logic dir_up;
    } pwaq_evt_t;

endpackage

// [hdl/pwaq_ctl_reg.sv]
// pwaq_ctl_reg.sv: one output's action control register
`timescale 1ns/1ps
`include "pwaq_params.svh"

module pwaq_ctl_reg
    import pwaq_pkg::*;
#(
    parameter logic [`PWAQ_CTL_W-1:0] RST_VAL = 12'h000
) (
    // clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    rst,
    input  wire logic                    ce,
    // write port
    input  wire logic                    wr_en,
    input  wire logic [15:0]             wr_data,
    input  wire logic [1:0]              wr_strb,
    // contents
    output pwaq_ctl_t                    ctl
);

    logic [`PWAQ_CTL_W-1:0] ctl_r;
    logic [`PWAQ_CTL_W-1:0] ctl_nxt;

    // upper nibble is reserved and never stored
    assign ctl_nxt = {wr_strb[1] ? wr_data[`PWAQ_CTL_USED_MSB:8] : ctl_r[`PWAQ_CTL_USED_MSB:8],
                      wr_strb[0] ? wr_data[7:0] : ctl_r[7:0]};

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctl_r <= RST_VAL;
        end else if (ce && wr_en) begin
            ctl_r <= ctl_nxt;
        end
    end

    assign ctl = pwaq_ctl_t'(ctl_r);

endmodule

// [hdl/pwaq_action_unit.sv]
// pwaq_action_unit.sv: event qualification and output flop for one pwm output
`timescale 1ns/1ps

module pwaq_action_unit
    import pwaq_pkg::*;
(
    // clock and reset
    input  wire logic      clk_sys,
    input  wire logic      rst,
    input  wire logic      ce,
    // control and events
    input  pwaq_ctl_t      ctl,
    input  pwaq_evt_t      evt,
    // output
    output logic           pwm_out
);

    logic      pwm_r;
    logic      pwm_nxt;
    pwaq_act_t act_compare_value_second;
    pwaq_act_t act_compare_value_first;
    pwaq_act_t act_per;
    pwaq_act_t act_zer;
    pwaq_act_t act_sel;

    // direction picks up or down field
    assign act_compare_value_second = !evt.eq_compare_value_second ? PWAQ_ACT_NONE :
                      evt.dir_up ? ctl.compare_value_second_up_action : ctl.compare_value_second_down_action;
    assign act_compare_value_first = !evt.eq_compare_value_first ? PWAQ_ACT_NONE :
                      evt.dir_up ? ctl.compare_value_first_up_action : ctl.compare_value_first_down_action;
    assign act_per  = evt.eq_period ? ctl.period_match_action : PWAQ_ACT_NONE;
    assign act_zer  = evt.eq_zero ? ctl.zero_match_action : PWAQ_ACT_NONE;

    // coincident events: first enabled one wins, so a disabled field never masks another
    assign act_sel = (act_compare_value_second != PWAQ_ACT_NONE) ? act_compare_value_second :
                     (act_compare_value_first != PWAQ_ACT_NONE) ? act_compare_value_first :
                     (act_per  != PWAQ_ACT_NONE) ? act_per  : act_zer;

    always_comb begin
        case (act_sel)
            PWAQ_ACT_CLEAR:  pwm_nxt = 1'b0;
            PWAQ_ACT_SET:    pwm_nxt = 1'b1;
            PWAQ_ACT_TOGGLE: pwm_nxt = ~pwm_r;
            default:         pwm_nxt = pwm_r;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pwm_r <= 1'b0;
        end else if (ce) begin
            pwm_r <= pwm_nxt;
        end
    end

    assign pwm_out = pwm_r;

endmodule

// [hdl/pwaq_top.sv]
// pwaq_top.sv: pwm action qualifier with its axi4-lite register slave
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "pwaq_params.svh"

// What this block does
// - On a compare-B match while counting down, each output takes the action in bits 11-10.
// - On a compare-B match while counting up, each output takes the action in bits 9-8.
// - On a compare-A match while counting down, each output takes the action in bits 7-6.
// - On a compare-A match while counting up, each output takes the action in bits 5-4.
// - On a period match, each output takes the action in bits 3-2.
// - On a zero match, each output takes the action in bits 1-0.
// - An action field of 00 leaves its output as it is.
// - An action field of 01 drives its output low.
// - An action field of 10 drives its output high.
// - An action field of 11 inverts its output.
// - In up-down mode the direction counts as down at a period match.
// - In up-down mode the direction counts as up at a zero match.
// - The first output's register has the same period and zero fields, acting on it alone.
// - The first output's register has the same compare fields, acting on it alone.
module pwaq_top
    import pwaq_pkg::*;
(
    // clock, reset, enable
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        ce,
    // time-base and compare events
    input  wire logic        tb_eq_zero,
    input  wire logic        tb_eq_period,
    input  wire logic        tb_eq_compare_value_first,
    input  wire logic        tb_eq_compare_value_second,
    input  wire logic        tb_dir_up,
    input  wire logic        tb_updown_mode,
    // pwm outputs to the dead-band stage
    output logic             pwm_out_first,
    output logic             pwm_out_second,
    // axi4-lite write address
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    // ==========================================================
    // write channel state
    logic                    aw_held_r;
    logic [`PWAQ_ADDR_W-1:0] aw_addr_r;
    logic                    w_held_r;
    logic [15:0]             w_data_r;
    logic [1:0]              w_strb_r;
    logic                    bvalid_r;
    logic [1:0]              bresp_r;
    logic [1:0]              bresp_nxt;

    wire aw_take  = s_axi_awvalid && s_axi_awready;
    wire w_take   = s_axi_wvalid && s_axi_wready;
    wire wr_do    = aw_held_r && w_held_r && !bvalid_r && ce;
    wire b_done   = s_axi_bvalid && s_axi_bready;

    // one write in flight: channels refuse while a response is pending
    assign s_axi_awready = ce && !aw_held_r && !bvalid_r;
    assign s_axi_wready  = ce && !w_held_r && !bvalid_r;

    // ==========================================================
    // write decode
    wire wr_sel_first  = (aw_addr_r == `PWAQ_OFS_CTL_FIRST);
    wire wr_sel_second = (aw_addr_r == `PWAQ_OFS_CTL_SECOND);
    wire wr_sel_status = (aw_addr_r == `PWAQ_OFS_STATUS);
    wire wr_mapped     = wr_sel_first || wr_sel_second || wr_sel_status;
    wire wr_en_first   = wr_do && wr_sel_first;
    wire wr_en_second  = wr_do && wr_sel_second;

    // status is read-only; a write there is accepted and ignored
    assign bresp_nxt = wr_mapped ? `PWAQ_RESP_OKAY : `PWAQ_RESP_SLVERR;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= '0;
        end else if (ce && aw_take) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= {s_axi_awaddr[`PWAQ_ADDR_W-1:2], 2'h0};
        end else if (wr_do) begin
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            w_held_r <= 1'b0;
            w_data_r <= '0;
            w_strb_r <= '0;
        end else if (ce && w_take) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata[15:0];
            w_strb_r <= s_axi_wstrb[1:0];
        end else if (wr_do) begin
            w_held_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bvalid_r <= 1'b0;
            bresp_r  <= `PWAQ_RESP_OKAY;
        end else if (wr_do) begin
            bvalid_r <= 1'b1;
            bresp_r  <= bresp_nxt;
        end else if (ce && b_done) begin
            bvalid_r <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp  = bresp_r;

    // ==========================================================
    // action control registers
    pwaq_ctl_t ctl_first;
    pwaq_ctl_t ctl_second;

    pwaq_ctl_reg #(
        .RST_VAL (`PWAQ_RST_CTL_FIRST)
    ) u_ctl_first (
        .clk_sys (clk_sys),
        .rst     (rst),
        .ce      (ce),
        .wr_en   (wr_en_first),
        .wr_data (w_data_r),
        .wr_strb (w_strb_r),
        .ctl     (ctl_first)
    );

    pwaq_ctl_reg #(
        .RST_VAL (`PWAQ_RST_CTL_SECOND)
    ) u_ctl_second (
        .clk_sys (clk_sys),
        .rst     (rst),
        .ce      (ce),
        .wr_en   (wr_en_second),
        .wr_data (w_data_r),
        .wr_strb (w_strb_r),
        .ctl     (ctl_second)
    );

    // ==========================================================
    // event qualification
    pwaq_evt_t evt;
    logic      dir_eff;
    logic      dir_last_r;

    // up-down mode overrides the raw direction at the turning points
    assign dir_eff = (tb_updown_mode && tb_eq_period) ? 1'b0 :
                     (tb_updown_mode && tb_eq_zero)   ? 1'b1 :
                     tb_dir_up;

    // same-clock inputs, used straight on the edge that updates the outputs
    assign evt = '{eq_zero:   tb_eq_zero,
                   eq_period: tb_eq_period,
                   eq_compare_value_first:   tb_eq_compare_value_first,
                   eq_compare_value_second:   tb_eq_compare_value_second,
                   dir_up:    dir_eff};

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dir_last_r <= 1'b1;
        end else if (ce) begin
            dir_last_r <= dir_eff;
        end
    end

    // ==========================================================
    // output action units
    pwaq_action_unit u_act_first (
        .clk_sys (clk_sys),
        .rst     (rst),
        .ce      (ce),
        .ctl     (ctl_first),
        .evt     (evt),
        .pwm_out (pwm_out_first)
    );

    pwaq_action_unit u_act_second (
        .clk_sys (clk_sys),
        .rst     (rst),
        .ce      (ce),
        .ctl     (ctl_second),
        .evt     (evt),
        .pwm_out (pwm_out_second)
    );

    // ==========================================================
    // read channel
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;
    logic [31:0] status_word;

    wire [`PWAQ_ADDR_W-1:0] rd_addr = {s_axi_araddr[`PWAQ_ADDR_W-1:2], 2'h0};
    wire ar_take       = s_axi_arvalid && s_axi_arready;
    wire r_done        = s_axi_rvalid && s_axi_rready;
    wire rd_sel_first  = (rd_addr == `PWAQ_OFS_CTL_FIRST);
    wire rd_sel_second = (rd_addr == `PWAQ_OFS_CTL_SECOND);
    wire rd_sel_status = (rd_addr == `PWAQ_OFS_STATUS);
    wire rd_mapped     = rd_sel_first || rd_sel_second || rd_sel_status;

    assign s_axi_arready = ce && !rvalid_r;

    always_comb begin
        status_word                       = 32'h0000_0000;
        status_word[`PWAQ_STS_OUT_FIRST]  = pwm_out_first;
        status_word[`PWAQ_STS_OUT_SECOND] = pwm_out_second;
        status_word[`PWAQ_STS_DIR]        = dir_last_r;
        status_word[`PWAQ_STS_UPDOWN]     = tb_updown_mode;
    end

    // reserved bits and unmapped words read as zero
    wire [31:0] rd_word = rd_sel_first  ? {20'h00000, ctl_first}  :
                          rd_sel_second ? {20'h00000, ctl_second} :
                          rd_sel_status ? status_word : 32'h0000_0000;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= `PWAQ_RESP_OKAY;
        end else if (ce && ar_take) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_word;
            rresp_r  <= rd_mapped ? `PWAQ_RESP_OKAY : `PWAQ_RESP_SLVERR;
        end else if (ce && r_done) begin
            rvalid_r <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata  = rdata_r;
    assign s_axi_rresp  = rresp_r;

    // prot bits carry no meaning here
    wire unused_prot = ^{s_axi_awprot, s_axi_arprot, s_axi_awaddr[31:`PWAQ_ADDR_W],
                         s_axi_araddr[31:`PWAQ_ADDR_W], s_axi_awaddr[1:0], s_axi_araddr[1:0],
                         s_axi_wdata[31:16], s_axi_wstrb[3:2], wr_sel_status};

endmodule

// [testbench/pwaq_top_chk.sv]
// pwaq_top_chk.sv: port checks on the action qualifier top
`timescale 1ns/1ps
module pwaq_top_chk (
    // clock, reset, enable
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        ce,
    // events and outputs
    input wire logic        tb_eq_zero,
    input wire logic        tb_eq_period,
    input wire logic        tb_eq_compare_value_first,
    input wire logic        tb_eq_compare_value_second,
    input wire logic        pwm_out_first,
    input wire logic        pwm_out_second,
    // bus handshakes
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire no_evt = !(tb_eq_zero || tb_eq_period || tb_eq_compare_value_first || tb_eq_compare_value_second);
    // ==========================================================
    // outputs
    a_quiet_hold: assert property (
        ce && no_evt |=> $stable(pwm_out_first) && $stable(pwm_out_second))
        else $error("pwm output moved without an event");
    a_freeze_hold: assert property (
        !ce |=> $stable(pwm_out_first) && $stable(pwm_out_second))
        else $error("pwm output moved while frozen");
    // ==========================================================
    // register bus
    a_write_answer: assert property (
        (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) ##1 ce
        |=> s_axi_bvalid) else $error("write response late");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read data late");
    a_rdata_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    a_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("write response dropped");
    a_read_busy: assert property (
        s_axi_rvalid |-> !s_axi_arready) else $error("read taken while data pending");
    a_ce_gate: assert property (
        !ce |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
        else $error("bus ready while frozen");
    c_toggle: cover property (tb_eq_compare_value_first ##1 $changed(pwm_out_first));
    c_rstall: cover property (s_axi_rvalid && !s_axi_rready);
    c_freeze: cover property (!ce && tb_eq_zero);
endmodule
bind pwaq_top pwaq_top_chk chk_u (.clk_sys, .rst, .ce, .tb_eq_zero, .tb_eq_period,
    .tb_eq_compare_value_first, .tb_eq_compare_value_second, .pwm_out_first, .pwm_out_second, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

// [testbench/pwaq_tbase_model.sv]
// pwaq_tbase_model.sv: time-base counter and compare stand-in
`timescale 1ns/1ps
module pwaq_tbase_model (
    // clock and control
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       run,
    input wire logic       updown,
    input wire logic [7:0] period,
    input wire logic [7:0] cmp_a,
    input wire logic [7:0] cmp_b,
    // events
    output logic           eq_zero,
    output logic           eq_period,
    output logic           eq_compare_value_first,
    output logic           eq_compare_value_second,
    output logic           dir_up
);
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic       dir_r;
    logic       dir_nxt;
    // stopped counter raises no events
    assign eq_zero   = run && cnt_r == 8'h00;
    assign eq_period = run && cnt_r == period;
    assign eq_compare_value_first   = run && cnt_r == cmp_a;
    assign eq_compare_value_second   = run && cnt_r == cmp_b;
    // raw direction: still up at the period turn, still down at zero
    assign dir_up    = dir_r;
    assign dir_nxt   = !updown || (cnt_r != period && (cnt_r == 8'h00 || dir_r));
    assign cnt_nxt   = (!updown && cnt_r == period) ? 8'h00 :
                       dir_nxt ? cnt_r + 8'h01 : cnt_r - 8'h01;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_r <= 8'h00;
            dir_r <= 1'h1;
        end else if (run) begin
            cnt_r <= cnt_nxt;
            dir_r <= dir_nxt;
        end
    end
endmodule

// [testbench/pwm_action_qualifier_tb_top.sv]
// pwm_action_qualifier_tb_top.sv: self-checking bench of the action qualifier
`timescale 1ns/1ps
`include "pwaq_params.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); end end
module pwm_action_qualifier_tb_top
    import pwaq_pkg::*;
;
    logic        clk_sys = 1'h0, rst = 1'h1, ce = 1'h1, run = 1'h0, updown = 1'h0;
    logic [7:0]  per_v = 8'h0A, cma_v = 8'h03, cmb_v = 8'h07;
    logic        eq_z, eq_p, eq_a, eq_b, dir_raw, pwm_a, pwm_b;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, rd;
    logic [3:0]  wstrb = '0;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid, slow = 0, chk_on = 0;
    logic [1:0]  bresp, rresp, rsp;
    logic [11:0] sh [2] = '{12'h000, 12'h000};
    logic        ex [2];
    int          miscompares = 0, n_tests = 0;
    pwaq_top dut_u (.clk_sys, .rst, .ce, .tb_eq_zero(eq_z), .tb_eq_period(eq_p),
        .tb_eq_compare_value_first(eq_a), .tb_eq_compare_value_second(eq_b), .tb_dir_up(dir_raw), .tb_updown_mode(updown),
        .pwm_out_first(pwm_a), .pwm_out_second(pwm_b), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    pwaq_tbase_model tbm_u (.clk_sys, .rst, .run, .updown, .period(per_v), .cmp_a(cma_v),
        .cmp_b(cmb_v), .eq_zero(eq_z), .eq_period(eq_p), .eq_compare_value_first(eq_a), .eq_compare_value_second(eq_b),
        .dir_up(dir_raw));
    initial forever #50 clk_sys = ~clk_sys;
    // ==========================================================
    // reference: priority compare_value_second, compare_value_first, period, zero; a 00 field never masks
    function automatic logic nxt(logic cur, logic [1:0] a);
        case (a)
            2'h1: return 1'h0;
            2'h2: return 1'h1;
            2'h3: return !cur;
            default: return cur;
        endcase
    endfunction
    always @(posedge clk_sys or posedge rst) begin : ref_model
        logic       up;
        logic [1:0] a;
        int         k;
        if (rst) begin
            ex[0] <= 1'h0;
            ex[1] <= 1'h0;
        end else if (ce) begin
            up = updown ? (eq_p ? 1'h0 : eq_z ? 1'h1 : dir_raw) : dir_raw;
            k = up ? 4 : 6;
            for (int i = 0; i < 2; i++) begin
                a = eq_z ? sh[i][1:0] : 2'h0;
                if (eq_p && sh[i][3:2] != 2'h0) a = sh[i][3:2];
                if (eq_a && sh[i][k+:2] != 2'h0) a = sh[i][k+:2];
                if (eq_b && sh[i][k+4+:2] != 2'h0) a = sh[i][k+4+:2];
                ex[i] <= nxt(ex[i], a);
            end
        end
    end
    always @(negedge clk_sys) begin
        if (chk_on) begin
            `CHK(pwm_a, ex[0])
            `CHK(pwm_b, ex[1])
        end
    end
    // ==========================================================
    // bus tasks; slow holds the ready back three cycles
    task automatic axi_wr(input logic [31:0] ad, input logic [31:0] d, input logic [3:0] st);
        bit a, w, b;
        int k;
        @(posedge clk_sys);
        awaddr <= ad;
        wdata <= d;
        wstrb <= st;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= !slow;
        b = 0;
        k = 0;
        while (!b) begin
            @(negedge clk_sys);
            a = awvalid && awready;
            w = wvalid && wready;
            b = bvalid && bready;
            rsp = bresp;
            @(posedge clk_sys);
            k++;
            if (a) awvalid <= 1'h0;
            if (w) wvalid <= 1'h0;
            if (b) bready <= 1'h0;
            else if (k == 3) bready <= 1'h1;
        end
    endtask
    task automatic rd_chk(input logic [31:0] ad, input logic [31:0] ed, input logic [1:0] er);
        bit a, r;
        int k;
        @(posedge clk_sys);
        araddr <= ad;
        arvalid <= 1'h1;
        rready <= !slow;
        r = 0;
        k = 0;
        while (!r) begin
            @(negedge clk_sys);
            a = arvalid && arready;
            r = rvalid && rready;
            rd = rdata;
            rsp = rresp;
            @(posedge clk_sys);
            k++;
            if (a) arvalid <= 1'h0;
            if (r) rready <= 1'h0;
            else if (k == 3) rready <= 1'h1;
        end
        `CHK(rd, ed)
        `CHK(rsp, er)
    endtask
    task automatic set_ctl(input int i, input logic [11:0] v);
        axi_wr(i ? `PWAQ_OFS_CTL_SECOND : `PWAQ_OFS_CTL_FIRST, {20'h0, v}, 4'h3);
        sh[i] = v;
    endtask
    task automatic run_cfg(input logic [11:0] a, input logic [11:0] b, input logic ud);
        set_ctl(0, a);
        set_ctl(1, b);
        @(posedge clk_sys);
        updown <= ud;
        run <= 1'h1;
        repeat (44) @(posedge clk_sys);
        run <= 1'h0;
    endtask
    // ==========================================================
    // scenarios
    task t_regs;
        rd_chk(`PWAQ_OFS_CTL_FIRST, 32'h0, `PWAQ_RESP_OKAY);
        rd_chk(`PWAQ_OFS_CTL_SECOND, 32'h0, `PWAQ_RESP_OKAY);
        // idle status: both outputs low, direction up, plain up mode
        rd_chk(`PWAQ_OFS_STATUS, 32'h0000_0004, `PWAQ_RESP_OKAY);
        axi_wr(`PWAQ_OFS_STATUS, 32'h0000_000F, 4'hF);
        `CHK(rsp, `PWAQ_RESP_OKAY)
        rd_chk(`PWAQ_OFS_STATUS, 32'h0000_0004, `PWAQ_RESP_OKAY);
        slow = 1;
        axi_wr(`PWAQ_OFS_CTL_FIRST, 32'hFFFF_FFFF, 4'h1);
        rd_chk(`PWAQ_OFS_CTL_FIRST, 32'h0000_00FF, `PWAQ_RESP_OKAY);
        axi_wr(`PWAQ_OFS_CTL_FIRST, 32'hFFFF_FFFF, 4'hF);
        rd_chk(`PWAQ_OFS_CTL_FIRST, 32'h0000_0FFF, `PWAQ_RESP_OKAY);
        axi_wr(`PWAQ_OFS_CTL_FIRST, 32'h0000_0000, 4'h2);
        rd_chk(`PWAQ_OFS_CTL_FIRST, 32'h0000_00FF, `PWAQ_RESP_OKAY);
        axi_wr(32'h0000_000C, 32'h1, 4'hF);
        `CHK(rsp, `PWAQ_RESP_SLVERR)
        rd_chk(32'h0000_000C, 32'h0, `PWAQ_RESP_SLVERR);
        slow = 0;
        set_ctl(0, 12'h000);
    endtask
    task t_direction;
        // compare at the turning points: only the override picks the field
        cma_v <= per_v;
        cmb_v <= 8'h00;
        run_cfg(12'h090, 12'h300, 1'h1);
        cma_v <= 8'h03;
        cmb_v <= 8'h07;
    endtask
    task t_priority;
        cma_v <= 8'h05;
        cmb_v <= 8'h05;
        run_cfg(12'h210, 12'h120, 1'h0);
        cma_v <= 8'h03;
        cmb_v <= 8'h07;
    endtask
    task t_freeze;
        logic a, b;
        set_ctl(0, 12'h00F);
        @(posedge clk_sys);
        run <= 1'h1;
        repeat (5) @(posedge clk_sys);
        ce <= 1'h0;
        // the edge that lowers ce still runs, so read once it has settled
        @(negedge clk_sys);
        a = pwm_a;
        b = pwm_b;
        repeat (12) @(negedge clk_sys);
        `CHK({pwm_a, pwm_b}, {a, b})
        @(posedge clk_sys);
        ce <= 1'h1;
        repeat (10) @(posedge clk_sys);
        run <= 1'h0;
    endtask
    task end_of_test;
        $display("miscompares=%0d n_tests=%0d", miscompares, n_tests);
        if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #500_000;
        miscompares++;
        end_of_test;
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'h0;
        chk_on <= 1'h1;
        t_regs;
        run_cfg(12'h090, 12'h600, 1'h1);
        run_cfg(12'h006, 12'h00F, 1'h1);
        run_cfg(12'hFF0, 12'h000, 1'h0);
        t_direction;
        t_priority;
        t_freeze;
        end_of_test;
    end
endmodule
